// >>> rtl/adc_consts.svh
// Constants of the flash converter back end: sizes, codes, reset values.
// Assumes inclusion by bare name from the package and the modules.
`ifndef ADC_BACKEND_CONSTS_SVH
`define ADC_BACKEND_CONSTS_SVH

// ----------------------------------------------------------------------
// Comparator array and decoder split
// ----------------------------------------------------------------------
`define THRESHOLDS      256
`define DEC_GROUPS      4
`define GROUP_WIDTH     64
`define COUNT_W         7
`define TOTAL_W         9
`define CODE_W          8

// ----------------------------------------------------------------------
// Code points
// ----------------------------------------------------------------------
`define FULL_SCALE      9'h100
`define CODE_MAX        8'hFF
`define CODE_ZERO       8'h00
`define LVL_M05         9'h0C0
`define LVL_M10         9'h080
`define LVL_M15         9'h040
`define GRAY_M05        8'hA0
`define GRAY_M10        8'hC0
`define GRAY_M15        8'h60
`define GRAY_TOP        8'h80

// ----------------------------------------------------------------------
// Result buffer and reset values
// ----------------------------------------------------------------------
`define FIFO_DEPTH      16
`define RESULT_W        9
`define RST_BIT         1'h0
`define RST_COUNT       7'h00

`endif

// >>> rtl/adc_pkg.sv
// Types shared by the converter back end and its testbench.
// Assumes adc_consts.svh on the include path.
`include "adc_consts.svh"

package adc_pkg;

    // One conversion result as it travels through the buffer
    typedef struct packed {
        logic                  over;
        logic [`CODE_W-1:0]    code;
    } result_s;

    // One output bank as seen by the capture logic
    typedef struct packed {
        logic [`CODE_W-1:0]    code;
        logic                  over;
        logic                  ready;
        logic                  ready_n;
    } bank_s;

    typedef logic [`DEC_GROUPS-1:0][`COUNT_W-1:0] group_count_t;

endpackage

// >>> rtl/flash_adc_backend.sv
// Digital back end of an 8-bit flash converter, two banked outputs.
// Assumes comparator decisions arrive synchronous to CLK, bit 255 top.
`timescale 1ns/1ps
`include "adc_consts.svh"

module flash_adc_backend
    import adc_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   NRST,
    input  wire logic [`THRESHOLDS-1:0] COMP_IN,
    input  wire logic                   CAPTURE_READY,
    output logic                        SAMPLE_READY,
    output logic      [`CODE_W-1:0]     BANK_A_CODE,
    output logic                        OVERRANGE_BIT_A,
    output logic                        BANK_A_READY,
    output logic                        BANK_A_READY_N,
    output logic      [`CODE_W-1:0]     BANK_B_CODE,
    output logic                        OVERRANGE_BIT_B,
    output logic                        BANK_B_READY,
    output logic                        BANK_B_READY_N
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                   sample_clock_reg;
    logic                   sample_clock_next;
    logic                   primed_reg;
    logic                   primed_next;
    logic [`THRESHOLDS-1:0] front_reg;
    logic [`THRESHOLDS-1:0] front_next;
    group_count_t           group_count;
    group_count_t           dec_reg;
    group_count_t           dec_next;
    group_count_t           latch_reg;
    group_count_t           latch_next;
    logic [`TOTAL_W-1:0]    total;
    logic [`CODE_W-1:0]     bin_code;
    result_s                wr_word;
    result_s                rd_word;
    logic                   wr_valid;
    logic                   wr_ready;
    logic                   rd_valid;
    logic                   pop;
    logic                   bank_sel_reg;
    logic                   bank_sel_next;
    bank_s                  bank_a_reg;
    bank_s                  bank_a_next;
    bank_s                  bank_b_reg;
    bank_s                  bank_b_next;

    // ------------------------------------------------------------------
    // Sample clock phase
    // ------------------------------------------------------------------
    // CLK/2 phase stands in for the sampling clock; its duty is 50% by
    // construction, which the source side would otherwise have to keep
    always_comb begin
        sample_clock_next = !sample_clock_reg;
        primed_next       = primed_reg || sample_clock_reg;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            sample_clock_reg <= `RST_BIT;
            primed_reg       <= `RST_BIT;
        end else begin
            sample_clock_reg <= sample_clock_next;
            primed_reg       <= primed_next;
        end
    end

    // ------------------------------------------------------------------
    // Comparator front stage and decoders
    // ------------------------------------------------------------------
    // Popcount per group also absorbs thermometer bubbles
    for (genvar g = 0; g < `DEC_GROUPS; g++) begin : g_dec
        assign group_count[g] =
            `COUNT_W'($countones(front_reg[g*`GROUP_WIDTH +: `GROUP_WIDTH]));
    end

    always_comb begin
        front_next = sample_clock_reg ? front_reg : COMP_IN;
        dec_next   = sample_clock_reg ? group_count : dec_reg;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            front_reg <= '0;
            dec_reg   <= {`DEC_GROUPS{`RST_COUNT}};
        end else begin
            front_reg <= front_next;
            dec_reg   <= dec_next;
        end
    end

    // ------------------------------------------------------------------
    // Tracking latches and output coding
    // ------------------------------------------------------------------
    always_comb begin
        latch_next = sample_clock_reg ? latch_reg : dec_reg;
        total      = '0;
        for (int i = 0; i < `DEC_GROUPS; i++) begin
            total = total + `TOTAL_W'(latch_next[i]);
        end
        wr_word.over = (total == `FULL_SCALE);
        bin_code     = wr_word.over ? `CODE_MAX : total[`CODE_W-1:0];
        wr_word.code = bin_code ^ (bin_code >> 1);
        wr_valid     = primed_reg && !sample_clock_reg;
        SAMPLE_READY = wr_ready;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            latch_reg <= {`DEC_GROUPS{`RST_COUNT}};
        end else begin
            latch_reg <= latch_next;
        end
    end

    // Results are dropped while SAMPLE_READY is low: a converter cannot
    // pause its sampling, so the capture side must keep up on average
    sample_fifo #(
        .WIDTH ($bits(result_s)),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .CLK      (CLK),
        .NRST     (NRST),
        .WR_VALID (wr_valid),
        .WR_DATA  (wr_word),
        .WR_READY (wr_ready),
        .RD_VALID (rd_valid),
        .RD_DATA  (rd_word),
        .RD_READY (CAPTURE_READY)
    );

    // ------------------------------------------------------------------
    // Output banks
    // ------------------------------------------------------------------
    always_comb begin
        pop           = rd_valid && CAPTURE_READY;
        bank_sel_next = pop ? !bank_sel_reg : bank_sel_reg;
        bank_a_next   = bank_a_reg;
        bank_b_next   = bank_b_reg;
        bank_a_next.ready   = pop && !bank_sel_reg;
        bank_a_next.ready_n = !(pop && !bank_sel_reg);
        bank_b_next.ready   = pop && bank_sel_reg;
        bank_b_next.ready_n = !(pop && bank_sel_reg);
        if (pop && !bank_sel_reg) begin
            bank_a_next.code = rd_word.code;
            bank_a_next.over = rd_word.over;
        end
        if (pop && bank_sel_reg) begin
            bank_b_next.code = rd_word.code;
            bank_b_next.over = rd_word.over;
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            bank_sel_reg <= `RST_BIT;
            bank_a_reg   <= '{`CODE_ZERO, `RST_BIT, `RST_BIT, !`RST_BIT};
            bank_b_reg   <= '{`CODE_ZERO, `RST_BIT, `RST_BIT, !`RST_BIT};
        end else begin
            bank_sel_reg <= bank_sel_next;
            bank_a_reg   <= bank_a_next;
            bank_b_reg   <= bank_b_next;
        end
    end

    always_comb begin
        BANK_A_CODE     = bank_a_reg.code;
        OVERRANGE_BIT_A = bank_a_reg.over;
        BANK_A_READY    = bank_a_reg.ready;
        BANK_A_READY_N  = bank_a_reg.ready_n;
        BANK_B_CODE     = bank_b_reg.code;
        OVERRANGE_BIT_B = bank_b_reg.over;
        BANK_B_READY    = bank_b_reg.ready;
        BANK_B_READY_N  = bank_b_reg.ready_n;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    chk_front_track: assert property (
        !sample_clock_reg |=> front_reg == $past(COMP_IN))
        else $error("front stage did not follow input");

    chk_front_freeze: assert property (
        sample_clock_reg && primed_reg |=> $stable(front_reg))
        else $error("frozen sample changed");

    chk_dec_sum: assert property (
        sample_clock_reg |=> (`TOTAL_W'(dec_reg[0]) + `TOTAL_W'(dec_reg[1])
            + `TOTAL_W'(dec_reg[2]) + `TOTAL_W'(dec_reg[3]))
            == `TOTAL_W'($countones($past(front_reg))))
        else $error("decoder sum wrong");

    chk_latch_hold: assert property (
        sample_clock_reg |=> $stable(latch_reg))
        else $error("latch changed outside tracking");

    chk_one_cycle: assert property (
        wr_valid |-> total == `TOTAL_W'($countones($past(front_reg))))
        else $error("result not from previous sample");

    chk_gray_step: assert property (
        wr_valid && !wr_word.over && total != '0 |->
            $countones(wr_word.code ^ ((total[`CODE_W-1:0] - 1'b1)
            ^ ((total[`CODE_W-1:0] - 1'b1) >> 1))) == 1)
        else $error("adjacent codes differ in more than one bit");

    chk_mid_codes: assert property (
        wr_valid |-> (total != `LVL_M05 || wr_word.code == `GRAY_M05)
            && (total != `LVL_M10 || wr_word.code == `GRAY_M10)
            && (total != `LVL_M15 || wr_word.code == `GRAY_M15)
            && (total != '0 || wr_word.code == `CODE_ZERO))
        else $error("fixed code point wrong");

    chk_over_top: assert property (
        wr_valid |-> wr_word.over == (total == `FULL_SCALE)
            && (!wr_word.over || wr_word.code == `GRAY_TOP))
        else $error("overrange bit wrong");

    chk_ready_pair: assert property (
        BANK_A_READY_N == !BANK_A_READY && BANK_B_READY_N == !BANK_B_READY)
        else $error("inverted ready does not match");

    chk_bank_alt: assert property (
        pop && !bank_sel_reg |=> BANK_A_READY && !BANK_B_READY
            && BANK_A_CODE == $past(rd_word.code) && bank_sel_reg)
        else $error("bank steering wrong");

    cov_bank_a: cover property (BANK_A_READY);
    cov_bank_b: cover property (BANK_B_READY ##2 BANK_A_READY);
    cov_overrange: cover property (wr_valid && wr_word.over);
    cov_fifo_full: cover property (!SAMPLE_READY);

endmodule

// >>> rtl/sample_fifo.sv
// Result buffer: synchronous FIFO, first word shown without a read.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "adc_consts.svh"

module sample_fifo #(
    parameter int WIDTH = `RESULT_W,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             CLK,
    input  wire logic             NRST,
    input  wire logic             WR_VALID,
    input  wire logic [WIDTH-1:0] WR_DATA,
    output logic                  WR_READY,
    output logic                  RD_VALID,
    output logic      [WIDTH-1:0] RD_DATA,
    input  wire logic             RD_READY
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW-1:0]    rd_ptr_next;
    logic [PW:0]      fill_reg;
    logic [PW:0]      fill_next;
    logic             do_wr;
    logic             do_rd;

    // ------------------------------------------------------------------
    // Pointers and fill level
    // ------------------------------------------------------------------
    always_comb begin
        WR_READY    = (fill_reg != (PW+1)'(DEPTH));
        RD_VALID    = (fill_reg != '0);
        RD_DATA     = mem_reg[rd_ptr_reg];
        do_wr       = WR_VALID && WR_READY;
        do_rd       = RD_VALID && RD_READY;
        wr_ptr_next = do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        fill_next   = fill_reg;
        if (do_wr && !do_rd) begin
            fill_next = fill_reg + 1'b1;
        end else if (do_rd && !do_wr) begin
            fill_next = fill_reg - 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg   <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            fill_reg   <= fill_next;
        end
    end

    // Storage is not reset; fill level alone says what is valid
    always_ff @(posedge CLK) begin
        if (do_wr) begin
            mem_reg[wr_ptr_reg] <= WR_DATA;
        end
    end

endmodule

// >>> tb/capture_model.sv
// Capture logic model: latches each bank word on its own ready strobe.
// Assumes bank outputs change just after the rising edge of CLK.
`timescale 1ns/1ps

module capture_model
    import adc_pkg::*;
(
    input  wire logic  CLK,
    input  wire logic  NRST,
    input  wire bank_s BANK_A,
    input  wire bank_s BANK_B,
    input  wire logic  STALL,
    output logic       CAPTURE_READY
);
    result_s words[$];
    int      bad_cnt = 0;
    logic    want_b;
    logic    prev_a;
    logic    prev_b;

    // ------------------------------------------------------------------
    // Acceptance
    // ------------------------------------------------------------------
    // Real capture logic may stall at any time, so the bench decides
    assign CAPTURE_READY = !STALL;

    // ------------------------------------------------------------------
    // Latching and strobe sanity
    // ------------------------------------------------------------------
    always @(posedge CLK) begin
        if (!NRST) begin
            want_b = 1'b0;
            prev_a = 1'b0;
            prev_b = 1'b0;
        end else begin
            if (BANK_A.ready_n === BANK_A.ready) bad_cnt++;
            if (BANK_B.ready_n === BANK_B.ready) bad_cnt++;
            // A strobe held two cycles would latch one word twice
            if (BANK_A.ready && prev_a) bad_cnt++;
            if (BANK_B.ready && prev_b) bad_cnt++;
            if (BANK_A.ready && BANK_B.ready) bad_cnt++;
            if (BANK_A.ready === 1'b1) begin
                if (want_b) bad_cnt++;
                words.push_back('{over: BANK_A.over, code: BANK_A.code});
                want_b = 1'b1;
            end
            if (BANK_B.ready === 1'b1) begin
                if (!want_b) bad_cnt++;
                words.push_back('{over: BANK_B.over, code: BANK_B.code});
                want_b = 1'b0;
            end
            prev_a = BANK_A.ready;
            prev_b = BANK_B.ready;
        end
    end
endmodule

// >>> tb/tb_top.sv
// Testbench of the converter back end with a capture logic model.
// Assumes adc_pkg and the design files are compiled before this file.
`timescale 1ns/1ps

module tb_top
    import adc_pkg::*;
;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic [255:0] comp_in = '0;
    logic         stall = 1'b0;
    logic         capture_ready;
    logic         sample_ready;
    logic [7:0]   a_code;
    logic [7:0]   b_code;
    logic         a_over, a_rdy, a_rdy_n;
    logic         b_over, b_rdy, b_rdy_n;
    bank_s        bank_a;
    bank_s        bank_b;
    int           n_mismatch = 0;
    int           checks_done = 0;

    // ------------------------------------------------------------------
    // Clock, design and capture model
    // ------------------------------------------------------------------
    always #50 clk = ~clk;

    assign bank_a = {a_code, a_over, a_rdy, a_rdy_n};
    assign bank_b = {b_code, b_over, b_rdy, b_rdy_n};

    flash_adc_backend dut_u (
        .CLK             (clk),
        .NRST            (nrst),
        .COMP_IN         (comp_in),
        .CAPTURE_READY   (capture_ready),
        .SAMPLE_READY    (sample_ready),
        .BANK_A_CODE     (a_code),
        .OVERRANGE_BIT_A (a_over),
        .BANK_A_READY    (a_rdy),
        .BANK_A_READY_N  (a_rdy_n),
        .BANK_B_CODE     (b_code),
        .OVERRANGE_BIT_B (b_over),
        .BANK_B_READY    (b_rdy),
        .BANK_B_READY_N  (b_rdy_n)
    );

    capture_model cap_u (
        .CLK           (clk),
        .NRST          (nrst),
        .BANK_A        (bank_a),
        .BANK_B        (bank_b),
        .STALL         (stall),
        .CAPTURE_READY (capture_ready)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [255:0] thermo(input int k);
        return {256{1'b1}} << (256 - k);
    endfunction

    // Full scale saturates the code; only the overrange bit tells it apart
    function automatic result_s expect_word(input int k);
        logic [7:0] b;
        b = (k > 255) ? 8'hFF : k[7:0];
        return '{over: (k == 256), code: b ^ (b >> 1)};
    endfunction

    task automatic cmp_word(input result_s got, input result_s exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic cmp_num(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            n_mismatch++;
            $display("[FAIL] %0t count got %0d exp %0d", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic reset_state();
        step(18);
        cmp_word({a_over, a_code}, '0);
        cmp_word({b_over, b_code}, '0);
        cmp_word({a_rdy, a_rdy_n, b_rdy, b_rdy_n, sample_ready}, 5'h0B);
        step(2);
        nrst = 1'b1;
    endtask

    task automatic sweep_codes();
        logic [7:0] pts [0:4];
        result_s    got;
        result_s    prev;
        pts = '{8'h00, 8'h60, 8'hC0, 8'hA0, 8'h80};
        for (int k = 0; k <= 256; k++) begin
            comp_in = thermo(k);
            step(12);
            got = cap_u.words[$];
            cmp_word(got, expect_word(k));
            cmp_word(cap_u.words[$-1], expect_word(k));
            if (k % 64 == 0) cmp_word(got, {k == 256, pts[k / 64]});
            if (k > 0 && k < 256) cmp_num($countones(got.code ^ prev.code), 1);
            prev = got;
        end
    endtask

    task automatic latency();
        int n;
        n = 0;
        comp_in = thermo(100);
        while (cap_u.words[$] !== expect_word(100) && n < 20) begin
            step(1);
            n++;
        end
        cmp_num(n >= 5 && n <= 6, 1);
    endtask

    task automatic fill_drain();
        int n0;
        int cnt;
        comp_in = thermo(30);
        step(10);
        stall = 1'b1;
        step(50);
        cmp_bit(sample_ready, 1'b0);
        n0 = cap_u.words.size();
        comp_in = thermo(31);
        step(10);
        cmp_num(cap_u.words.size(), n0);
        cap_u.words.delete();
        stall = 1'b0;
        step(60);
        cnt = 0;
        foreach (cap_u.words[i]) begin
            if (cap_u.words[i] === expect_word(30)) cnt++;
        end
        cmp_num(cnt, 16);
        cmp_word(cap_u.words[$], expect_word(31));
        cmp_bit(sample_ready, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence, watchdog and verdict
    // ------------------------------------------------------------------
    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        reset_state();
        sweep_codes();
        latency();
        fill_drain();
        cmp_num(cap_u.bad_cnt, 0);
        close_out();
    end

    // About 3,250 cycles are needed; three times that is allowed
    initial begin
        #1_000_000;
        n_mismatch++;
        close_out();
    end
endmodule
